//--- hw/tksns_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the touch sense unit
// Assumes: Register index times four is the byte address on the bus
// Notes:   Definitions only
`ifndef TKSNS_CFG_SVH
`define TKSNS_CFG_SVH
`define TKSNS_IDX_INT_EN     6'h08
`define TKSNS_IDX_INT_FLAG   6'h09
`define TKSNS_IDX_CTL        6'h14
`define TKSNS_IDX_SCAN_CTL   6'h15
`define TKSNS_IDX_STATUS     6'h16
`define TKSNS_IDX_CNT_LOW    6'h17
`define TKSNS_IDX_THR_LO0    6'h18
`define TKSNS_IDX_THR_HI10   6'h1C
`define TKSNS_IDX_THR_HI32   6'h1D
`define TKSNS_FLAG_MASK      8'h3D
`define TKSNS_BIT_AUTO       5
`define TKSNS_BIT_TMR0       4
`define TKSNS_BIT_WKT        3
`define TKSNS_BIT_EXT2       2
`define TKSNS_BIT_EXT0       0
`define TKSNS_BIT_PD         7
`define TKSNS_BIT_CHX        4
`define TKSNS_BIT_SOC        3
`define TKSNS_BIT_SCAN_EN    2
`define TKSNS_CTL_RST        8'hC0
`define TKSNS_CTL_MASK_A     8'hFB
`define TKSNS_CTL_MASK_B     8'hFB
`define TKSNS_SCAN_RST       3'h3
`define TKSNS_THR_LO_RST     8'h28
`define TKSNS_THR_HI_RST     3'h0
`define TKSNS_REF_CH         2'h3
`define TKSNS_BASE_NS        2560
`define TKSNS_CLK_NS         40
`endif

//--- hw/tksns_pkg.sv
// Purpose: Types shared by the touch sense unit
// Assumes: Constants live in tksns_cfg.svh
// Notes:   Nothing here is imported; users write tksns_pkg::name
package tksns_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CONV = 2'b01,
      ST_DONE = 2'b10
   } tksns_state_e;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] idx;
   } tksns_req_s;
   typedef struct packed {
      logic       ovf;
      logic [9:0] count;
      logic       eoc;
      logic [3:0] touched;
   } tksns_res_s;
endpackage

//--- hw/tksns_top.sv
// Purpose: Touch key measurement, auto scan and shared pending flags behind AHB-Lite
// Assumes: Oscillator and interrupt pins are asynchronous; timer pulses share REF_CLK_IN
// Notes:   Reads take one wait state, writes none; responses are always OKAY
`timescale 1ns/1ps
`include "tksns_cfg.svh"
// Summary of operation
// - Auto scan sets the auto touch pending flag when a key is touched.
// - Writing 0 to a pending flag clears it; writing 1 leaves it.
// - Timer 0 overflow pulse sets its pending flag.
// - Wakeup timer timeout pulse sets its pending flag.
// - Falling edge of external pin 2 sets its pending flag.
// - Either edge of external pin 0 sets its pending flag.
// - Power down bit stops the unit when 1; resets to 1.
// - First variant: 3-bit conversion time, eight levels, reset 4.
// - Second variant: 2-bit time maps to levels 0,2,4,6, reset 2.
// - Second variant: extra bit with channel 3 picks reference, else invalid.
// - Rising edge of the start bit launches a single conversion.
// - Start bit clears itself when the conversion finishes.
// - Channel field picks touch channel 0 to 3, reset 0.
// - Auto scan enable runs hardware scanning; otherwise only single conversions.
// - Scan count field scans channels 0 up to 0..3, reset 3.
// - Scan result holds one touch bit per channel, reset 0.
// - End of conversion reads 0 while converting, 1 once done.
// - Overflow reads 1 when the counter overflowed during conversion.
// - Ten-bit count split: high two bits in status, low eight separate.
// - Auto touch interrupt enable gates its flag; reset 0.
// - Each channel has an 11-bit threshold, low reset 40, high 0.
module tksns_top #(
   parameter bit          VARIANT_B   = 1'b0,
   parameter int unsigned BASE_CYCLES = ((`TKSNS_BASE_NS + `TKSNS_CLK_NS - 1) / `TKSNS_CLK_NS)
) (
   input  wire logic        REF_CLK_IN,
   input  wire logic        ARST_N_IN,
   input  wire logic        HSEL_IN,
   input  wire logic [31:0] HADDR_IN,
   input  wire logic [1:0]  HTRANS_IN,
   input  wire logic        HWRITE_IN,
   input  wire logic [2:0]  HSIZE_IN,
   input  wire logic [31:0] HWDATA_IN,
   input  wire logic        HREADY_IN,
   output logic             HREADYOUT_OUT,
   output logic             HRESP_OUT,
   output logic [31:0]      HRDATA_OUT,
   input  wire logic [4:0]  TOUCH_OSC_IN,
   input  wire logic        EXT_IRQ0_PIN_IN,
   input  wire logic        EXT_IRQ2_PIN_IN,
   input  wire logic        TIMER0_OVF_IN,
   input  wire logic        WAKEUP_TIMEOUT_IN,
   output logic [1:0]       TOUCH_CH_SEL_OUT,
   output logic             TOUCH_POWER_DOWN_OUT,
   output logic             IRQ_OUT
);
   localparam int unsigned WIN_W = 16;

   tksns_pkg::tksns_state_e state_r, state_nxt;
   tksns_pkg::tksns_req_s   req_r;
   tksns_pkg::tksns_res_s   res_r;
   logic [7:0]       int_en_r;
   logic [7:0]       flags_r;
   logic [7:0]       ctl_r;
   logic [2:0]       scan_ctl_r;
   logic [7:0]       thr_lo_r [4];
   logic [2:0]       thr_hi_r [4];
   logic [6:0]       sy1_r, sy2_r, sy3_r, lvl_r;
   logic [2:0]       arm_r;
   logic             soc_prev_r;
   logic [1:0]       scan_ch_r;
   logic [WIN_W-1:0] win_r;
   logic [31:0]      hrdata_r;
   logic             hready_r;
   logic             irq_r;
   logic [1:0]       ch_out_r;
   logic             pd_out_r;

   // Synchronised pin levels: [4:0] oscillators, 5 pin 0, 6 pin 2
   wire [6:0] pins_raw   = {EXT_IRQ2_PIN_IN, EXT_IRQ0_PIN_IN, TOUCH_OSC_IN};
   wire [6:0] lvl_nxt    = (sy2_r == sy3_r) ? sy3_r : lvl_r;
   // Edges are masked until the samplers have filled once after reset, so a pin
   // idling high cannot fake an edge; a change in those first cycles is lost
   wire       armed      = arm_r[2];
   wire [6:0] rise       = lvl_nxt & ~lvl_r & {7{armed}};
   wire [6:0] fall       = ~lvl_nxt & lvl_r & {7{armed}};

   // Bus decode
   wire       accept     = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
   wire       wr_now     = req_r.wr;
   wire [7:0] wdat       = HWDATA_IN[7:0];

   // Control fields
   wire       pd         = ctl_r[`TKSNS_BIT_PD];
   wire       soc        = ctl_r[`TKSNS_BIT_SOC];
   wire       chx        = VARIANT_B & ctl_r[`TKSNS_BIT_CHX];
   wire [1:0] ch_sel     = ctl_r[1:0];
   wire       scan_en    = scan_ctl_r[`TKSNS_BIT_SCAN_EN];
   wire [1:0] scan_num   = scan_ctl_r[1:0];
   wire [2:0] level      = VARIANT_B ? {ctl_r[6:5], 1'b0} : ctl_r[6:4];
   wire [WIN_W-1:0] win_len = WIN_W'(BASE_CYCLES) << level;

   // Channel in use and its oscillator
   wire [1:0] act_ch     = scan_en ? scan_ch_r : ch_sel;
   wire       ref_sel    = chx & (act_ch == `TKSNS_REF_CH) & ~scan_en;
   wire       ch_bad     = chx & (act_ch != `TKSNS_REF_CH) & ~scan_en;
   wire       osc_edge   = ch_bad ? 1'b0 : (ref_sel ? rise[4] : rise[act_ch]);

   wire       soc_rise   = soc & ~soc_prev_r;
   wire       start_one  = (state_r == tksns_pkg::ST_IDLE) & ~pd & ~scan_en & soc_rise;
   wire       start_auto = (state_r == tksns_pkg::ST_IDLE) & ~pd & scan_en;
   wire       conv_end   = (state_r == tksns_pkg::ST_CONV) & (win_r == win_len);
   wire       cnt_full   = (res_r.count == 10'h3FF);

   // Touch means fewer oscillations than the threshold
   wire [10:0] thr       = {thr_hi_r[scan_ch_r], thr_lo_r[scan_ch_r]};
   wire        touched   = {res_r.ovf, res_r.count} < thr;
   wire        auto_end  = conv_end & scan_en;
   wire        auto_hit  = auto_end & touched;
   wire [1:0]  scan_nxt  = (scan_ch_r >= scan_num) ? 2'h0 : scan_ch_r + 2'h1;

   // Flag sets and software clears; the set wins
   wire [7:0] flag_set;
   assign flag_set[`TKSNS_BIT_AUTO] = auto_hit;
   assign flag_set[`TKSNS_BIT_TMR0] = TIMER0_OVF_IN;
   assign flag_set[`TKSNS_BIT_WKT]  = WAKEUP_TIMEOUT_IN;
   assign flag_set[`TKSNS_BIT_EXT2] = fall[6];
   assign flag_set[`TKSNS_BIT_EXT0] = rise[5] | fall[5];
   assign flag_set[7:6]             = 2'h0;
   assign flag_set[1]               = 1'b0;
   wire       wr_flags   = wr_now & (req_r.idx == `TKSNS_IDX_INT_FLAG);
   wire [7:0] flag_clr   = wr_flags ? ~wdat : 8'h00;
   wire [7:0] flags_nxt  = ((flags_r & ~flag_clr) | flag_set) & `TKSNS_FLAG_MASK;

   wire       wr_ctl     = wr_now & (req_r.idx == `TKSNS_IDX_CTL);
   wire [7:0] ctl_mask   = VARIANT_B ? `TKSNS_CTL_MASK_B : `TKSNS_CTL_MASK_A;
   wire [7:0] ctl_wr     = wr_ctl ? (wdat & ctl_mask) : ctl_r;
   // Hardware clear beats a write landing in the same cycle
   wire [7:0] ctl_nxt    = conv_end ? (ctl_wr & ~(8'h01 << `TKSNS_BIT_SOC)) : ctl_wr;

   // Read mux
   wire [7:0] status_rd  = {res_r.touched, res_r.eoc, res_r.ovf, res_r.count[9:8]};
   wire [7:0] rd_byte    =
      (req_r.idx == `TKSNS_IDX_INT_EN)   ? int_en_r :
      (req_r.idx == `TKSNS_IDX_INT_FLAG) ? flags_r :
      (req_r.idx == `TKSNS_IDX_CTL)      ? ctl_r :
      (req_r.idx == `TKSNS_IDX_SCAN_CTL) ? {5'h00, scan_ctl_r} :
      (req_r.idx == `TKSNS_IDX_STATUS)   ? status_rd :
      (req_r.idx == `TKSNS_IDX_CNT_LOW)  ? res_r.count[7:0] :
      (req_r.idx >= `TKSNS_IDX_THR_LO0 && req_r.idx < `TKSNS_IDX_THR_HI10) ?
         thr_lo_r[req_r.idx[1:0]] :
      (req_r.idx == `TKSNS_IDX_THR_HI10) ? {1'b0, thr_hi_r[1], 1'b0, thr_hi_r[0]} :
      (req_r.idx == `TKSNS_IDX_THR_HI32) ? {1'b0, thr_hi_r[3], 1'b0, thr_hi_r[2]} :
      8'h00;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         tksns_pkg::ST_IDLE: begin
            if (start_one || start_auto) begin
               state_nxt = tksns_pkg::ST_CONV;
            end
         end
         tksns_pkg::ST_CONV: begin
            if (pd) begin
               state_nxt = tksns_pkg::ST_IDLE;
            end else if (conv_end) begin
               state_nxt = tksns_pkg::ST_DONE;
            end
         end
         tksns_pkg::ST_DONE: state_nxt = tksns_pkg::ST_IDLE;
         default: state_nxt = tksns_pkg::ST_IDLE;
      endcase
   end

   // Pin synchronisers: only sy2 reads sy1
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         sy1_r <= 7'h00;
         sy2_r <= 7'h00;
         sy3_r <= 7'h00;
         lvl_r <= 7'h00;
         arm_r <= 3'h0;
      end else begin
         sy1_r <= pins_raw;
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         lvl_r <= lvl_nxt;
         arm_r <= armed ? arm_r : arm_r + 3'h1;
      end
   end

   // Bus slave: reads wait one cycle so a write just before is seen
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         req_r    <= '0;
         hready_r <= 1'b1;
         hrdata_r <= 32'h0000_0000;
      end else begin
         req_r.wr  <= accept & HWRITE_IN;
         req_r.rd  <= accept & ~HWRITE_IN;
         if (accept) begin
            req_r.idx <= HADDR_IN[7:2];
         end
         hready_r <= ~(accept & ~HWRITE_IN);
         if (req_r.rd) begin
            hrdata_r <= {24'h00_0000, rd_byte};
         end
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         int_en_r   <= 8'h00;
         flags_r    <= 8'h00;
         ctl_r      <= `TKSNS_CTL_RST;
         scan_ctl_r <= {1'b0, 2'(`TKSNS_SCAN_RST)};
         soc_prev_r <= 1'b0;
      end else begin
         flags_r    <= flags_nxt;
         ctl_r      <= ctl_nxt;
         soc_prev_r <= soc;
         if (wr_now && req_r.idx == `TKSNS_IDX_INT_EN) begin
            int_en_r <= wdat & `TKSNS_FLAG_MASK;
         end
         if (wr_now && req_r.idx == `TKSNS_IDX_SCAN_CTL) begin
            scan_ctl_r <= wdat[2:0];
         end
      end
   end

   // Thresholds, one per channel
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_thr
         always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
               thr_lo_r[g] <= `TKSNS_THR_LO_RST;
               thr_hi_r[g] <= `TKSNS_THR_HI_RST;
            end else if (wr_now) begin
               if (req_r.idx == `TKSNS_IDX_THR_LO0 + 6'(g)) begin
                  thr_lo_r[g] <= wdat;
               end
               if (req_r.idx == `TKSNS_IDX_THR_HI10 + 6'(g / 2)) begin
                  thr_hi_r[g] <= wdat[4*(g%2) +: 3];
               end
            end
         end
      end
   endgenerate

   // Measurement
   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_r   <= tksns_pkg::ST_IDLE;
         res_r     <= '0;
         win_r     <= '0;
         scan_ch_r <= 2'h0;
      end else begin
         state_r <= state_nxt;
         if (start_one || start_auto) begin
            win_r         <= '0;
            res_r.count   <= 10'h000;
            res_r.ovf     <= 1'b0;
            res_r.eoc     <= 1'b0;
         end else if (state_r == tksns_pkg::ST_CONV && !conv_end) begin
            win_r <= win_r + WIN_W'(1);
            if (osc_edge) begin
               res_r.count <= res_r.count + 10'h001;
               if (cnt_full) begin
                  res_r.ovf <= 1'b1;
               end
            end
         end
         if (conv_end || (state_r == tksns_pkg::ST_CONV && pd)) begin
            res_r.eoc <= 1'b1;
         end
         if (auto_end) begin
            res_r.touched[scan_ch_r] <= touched;
            scan_ch_r                <= scan_nxt;
         end else if (!scan_en || scan_ch_r > scan_num) begin
            scan_ch_r <= 2'h0;
         end
      end
   end

   always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         irq_r    <= 1'b0;
         ch_out_r <= 2'h0;
         pd_out_r <= 1'b1;
      end else begin
         irq_r    <= |(flags_r & int_en_r);
         ch_out_r <= act_ch;
         pd_out_r <= pd;
      end
   end

   assign HREADYOUT_OUT        = hready_r;
   assign HRESP_OUT            = 1'b0;
   assign HRDATA_OUT           = hrdata_r;
   assign TOUCH_CH_SEL_OUT     = ch_out_r;
   assign TOUCH_POWER_DOWN_OUT = pd_out_r;
   assign IRQ_OUT              = irq_r;

   auto_flag_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      auto_hit |=> flags_r[`TKSNS_BIT_AUTO])
      else $error("auto touch flag not set");
   flag_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      wr_flags && !wdat[`TKSNS_BIT_TMR0] && !TIMER0_OVF_IN |=> !flags_r[`TKSNS_BIT_TMR0])
      else $error("timer flag not cleared by zero write");
   flag_keep_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      wr_flags && wdat[`TKSNS_BIT_WKT] && flags_r[`TKSNS_BIT_WKT] |=> flags_r[`TKSNS_BIT_WKT])
      else $error("flag lost on one write");
   tmr_flag_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      TIMER0_OVF_IN |=> flags_r[`TKSNS_BIT_TMR0])
      else $error("timer flag missed");
   wkt_flag_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      WAKEUP_TIMEOUT_IN |=> flags_r[`TKSNS_BIT_WKT])
      else $error("wakeup flag missed");
   soc_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      conv_end |=> !soc ##1 res_r.eoc)
      else $error("start bit not cleared at end");
   eoc_busy_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      $rose(state_r == tksns_pkg::ST_CONV) |-> !res_r.eoc)
      else $error("end flag high while converting");
   irq_follow_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      IRQ_OUT == $past(|(flags_r & int_en_r)))
      else $error("interrupt request mismatch");
   scan_range_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      auto_end && scan_ch_r == scan_num |=> scan_ch_r == 2'h0)
      else $error("scan did not wrap");
   pd_stop_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      pd && state_r != tksns_pkg::ST_CONV |=> state_r != tksns_pkg::ST_CONV)
      else $error("conversion while powered down");
   ext2_fall_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      fall[6] |=> flags_r[`TKSNS_BIT_EXT2])
      else $error("pin 2 falling edge missed");
   ext0_edge_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      rise[5] || fall[5] |=> flags_r[`TKSNS_BIT_EXT0])
      else $error("pin 0 edge missed");
   soc_start_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      $rose(soc) && state_r == tksns_pkg::ST_IDLE && !pd && !scan_en
         |=> state_r == tksns_pkg::ST_CONV)
      else $error("start bit edge did not launch");
   ovf_flag_a: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
      state_r == tksns_pkg::ST_CONV && !conv_end && osc_edge && cnt_full |=> res_r.ovf)
      else $error("counter overflow not flagged");
endmodule

//--- test/tksns_pad_model.sv
// Purpose: Touch electrode pads as the measurement unit sees them
// Assumes: A pad oscillates only while the unit is powered up
// Notes:   A touched pad runs slow, so it yields a small count
`timescale 1ns/1ps
module tksns_pad_model #(
   // Each half must span two clocks, or the pin sampler can miss the level
   parameter int FAST_HALF_NS = 100,
   parameter int SLOW_HALF_NS = 1000
) (
   input  wire logic       power_down_in,
   input  wire logic [4:0] touched_in,
   output logic      [4:0] osc_out
);
   logic pad_lvl [5];
   for (genvar i = 0; i < 5; i++) begin : g_pad
      initial begin
         pad_lvl[i] = 1'b0;
         forever begin
            // Powered down pads stand still, so a stale edge cannot be counted
            if (power_down_in !== 1'b0) begin
               pad_lvl[i] = 1'b0;
               @(power_down_in);
            end else begin
               #(touched_in[i] ? SLOW_HALF_NS : FAST_HALF_NS);
               pad_lvl[i] = ~pad_lvl[i];
            end
         end
      end
   end
   assign osc_out = {pad_lvl[4], pad_lvl[3], pad_lvl[2], pad_lvl[1], pad_lvl[0]};
endmodule

//--- test/tksns_test.sv
// Purpose: Self-checking bench for the touch sense unit and its pending flags
// Assumes: BASE_CYCLES of 2 keeps every conversion window short
// Notes:   Registers are reached by AHB-Lite single word transfers
`timescale 1ns/1ps
`include "tksns_cfg.svh"
module tksns_test;
   logic        clk, arst_n, hsel, hwrite, ext0, ext2, tmr, wakeup_timer;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata;
   logic [4:0]  touched;
   logic [7:0]  rd, lo;
   wire logic   hreadyout, hresp, irq, pd;
   wire logic [31:0] hrdata;
   wire logic [1:0]  chsel;
   wire logic [4:0]  osc;
   int          fails, num_checks, n;
   logic [5:0]  ridx [13] = '{`TKSNS_IDX_INT_EN, `TKSNS_IDX_INT_FLAG, `TKSNS_IDX_CTL,
      `TKSNS_IDX_SCAN_CTL, `TKSNS_IDX_STATUS, `TKSNS_IDX_CNT_LOW, 6'h18, 6'h19, 6'h1A,
      6'h1B, `TKSNS_IDX_THR_HI10, `TKSNS_IDX_THR_HI32, 6'h3F};
   logic [7:0]  rexp [13] = '{8'h00, 8'h00, 8'hC0, 8'h03, 8'h00, 8'h00, 8'h28, 8'h28,
      8'h28, 8'h28, 8'h00, 8'h00, 8'h00};
   logic [1:0]  cch [2] = '{2'h2, 2'h1};
   logic [9:0]  clo [2] = '{10'h005, 10'h000};
   logic [9:0]  chi [2] = '{10'h008, 10'h001};

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   tksns_top #(.VARIANT_B(1'b0), .BASE_CYCLES(2)) u_dut (
      .REF_CLK_IN(clk), .ARST_N_IN(arst_n), .HSEL_IN(hsel), .HADDR_IN(haddr),
      .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
      .HREADY_IN(hreadyout), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp),
      .HRDATA_OUT(hrdata), .TOUCH_OSC_IN(osc), .EXT_IRQ0_PIN_IN(ext0),
      .EXT_IRQ2_PIN_IN(ext2), .TIMER0_OVF_IN(tmr), .WAKEUP_TIMEOUT_IN(wakeup_timer),
      .TOUCH_CH_SEL_OUT(chsel), .TOUCH_POWER_DOWN_OUT(pd), .IRQ_OUT(irq));
   tksns_pad_model u_pads (.power_down_in(pd), .touched_in(touched), .osc_out(osc));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_rng(input logic [9:0] got, input logic [9:0] lo_b, input logic [9:0] hi_b);
      num_checks++;
      if ($isunknown(got) || got < lo_b || got > hi_b) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo_b, hi_b);
      end
   endtask
   // Bounded so a stuck slave ends as a mismatch, not a hang
   task automatic wait_ready;
      int k;
      k = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1 && k < 64) begin
         k++;
         @(posedge clk);
      end
      if (k == 64) chk_bit(hreadyout, 1'b1);
   endtask
   task automatic ahb_write(input logic [5:0] idx, input logic [7:0] d);
      haddr  <= {24'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= 1'b1;
      hsel   <= 1'b1;
      wait_ready;
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= {24'h0, d};
      wait_ready;
   endtask
   task automatic ahb_read(input logic [5:0] idx, output logic [7:0] d);
      haddr  <= {24'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= 1'b0;
      hsel   <= 1'b1;
      wait_ready;
      htrans <= 2'b00;
      hsel   <= 1'b0;
      wait_ready;
      d = hrdata[7:0];
   endtask
   task automatic print_verdict;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      print_verdict;
   end

   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, ext0, tmr, wakeup_timer} = '0;
      ext2 = 1'b1;
      touched = 5'b00010;
      fails = 0;
      num_checks = 0;
      arst_n = 1'b0;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      chk_bit(pd, 1'b1);
      for (int i = 0; i < 13; i++) begin
         ahb_read(ridx[i], rd);
         chk(rd, rexp[i]);
      end
      ahb_write(`TKSNS_IDX_STATUS, 8'hFF);
      ahb_write(`TKSNS_IDX_CNT_LOW, 8'hFF);
      ahb_read(`TKSNS_IDX_STATUS, rd);
      chk(rd, 8'h00);
      ahb_read(`TKSNS_IDX_CNT_LOW, rd);
      chk(rd, 8'h00);
      ahb_write(`TKSNS_IDX_CTL, 8'h73);
      ahb_read(`TKSNS_IDX_CTL, rd);
      chk(rd, 8'h73);
      chk_bit(pd, 1'b0);
      chk({6'h0, chsel}, 8'h03);
      ahb_write(`TKSNS_IDX_CTL, 8'hC0);
      $display("test registers done");

      tmr <= 1'b1;
      @(posedge clk) tmr <= 1'b0;
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h10);
      ahb_write(`TKSNS_IDX_INT_EN, 8'h10);
      repeat (3) @(posedge clk);
      chk_bit(irq, 1'b1);
      ahb_write(`TKSNS_IDX_INT_FLAG, 8'hEF);
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h00);
      wakeup_timer <= 1'b1;
      @(posedge clk) wakeup_timer <= 1'b0;
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h08);
      ext2 <= 1'b0;
      repeat (10) @(posedge clk);
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h0C);
      ext2 <= 1'b1;
      ext0 <= 1'b1;
      repeat (10) @(posedge clk);
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h0D);
      chk_bit(irq, 1'b0);
      ahb_write(`TKSNS_IDX_INT_FLAG, 8'hFE);
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h0C);
      ext0 <= 1'b0;
      repeat (10) @(posedge clk);
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h0D);
      ahb_write(`TKSNS_IDX_INT_FLAG, 8'h00);
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h00);
      $display("test flags done");

      ahb_write(`TKSNS_IDX_INT_EN, 8'h00);
      for (int c = 0; c < 2; c++) begin
         ahb_write(`TKSNS_IDX_CTL, {6'h10, cch[c]});
         ahb_write(`TKSNS_IDX_CTL, {6'h12, cch[c]});
         ahb_read(`TKSNS_IDX_STATUS, rd);
         chk(rd & 8'h08, 8'h00);
         n = 0;
         do begin
            ahb_read(`TKSNS_IDX_STATUS, rd);
            n++;
         end while (rd[3] !== 1'b1 && n < 100);
         chk(rd & 8'h0C, 8'h08);
         chk({6'h0, chsel}, {6'h0, cch[c]});
         ahb_read(`TKSNS_IDX_CNT_LOW, lo);
         chk_rng({rd[1:0], lo}, clo[c], chi[c]);
         ahb_read(`TKSNS_IDX_CTL, rd);
         chk(rd, {6'h10, cch[c]});
      end
      $display("test single conversion done");

      for (int i = 0; i < 4; i++) ahb_write(6'h18 + 6'(i), 8'h04);
      ahb_write(`TKSNS_IDX_INT_EN, 8'h20);
      ahb_write(`TKSNS_IDX_SCAN_CTL, 8'h05);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         n++;
         @(posedge clk);
      end
      chk_bit(irq, 1'b1);
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h20);
      ahb_read(`TKSNS_IDX_STATUS, rd);
      chk(rd & 8'hF0, 8'h20);
      ahb_write(`TKSNS_IDX_SCAN_CTL, 8'h04);
      repeat (100) @(posedge clk);
      ahb_write(`TKSNS_IDX_INT_FLAG, 8'hDF);
      repeat (300) @(posedge clk);
      ahb_read(`TKSNS_IDX_INT_FLAG, rd);
      chk(rd, 8'h00);
      chk_bit(irq, 1'b0);
      touched <= 5'b00001;
      repeat (300) @(posedge clk);
      ahb_read(`TKSNS_IDX_STATUS, rd);
      chk(rd & 8'h10, 8'h10);
      chk_bit(irq, 1'b1);
      $display("test auto scan done");
      print_verdict;
   end
endmodule
